// ---- ocd_pkg.sv ----
// Purpose: shared constants and types for the opcode decode and timing block
// Assumes: opcodes arrive as one byte, synchronous to clk_sys_i
// Notes:   cycle counts are bus-clock cycles; lengths are bytes
package ocd_pkg;

  // instruction classes
  typedef enum logic [3:0] {
    OCD_CLS_NONE       = 4'h0,
    OCD_CLS_LOAD_ACC   = 4'h1,
    OCD_CLS_LOAD_INDEX = 4'h2,
    OCD_CLS_STORE_ACC  = 4'h3,
    OCD_CLS_STORE_IDX  = 4'h4,
    OCD_CLS_ALU        = 4'h5,
    OCD_CLS_COMPARE    = 4'h6,
    OCD_CLS_JUMP       = 4'h7,
    OCD_CLS_JUMP_SUB   = 4'h8,
    OCD_CLS_BRANCH     = 4'h9,
    OCD_CLS_BRANCH_SUB = 4'hA,
    OCD_CLS_BIT_BRANCH = 4'hB,
    OCD_CLS_BIT_SETCLR = 4'hC
  } ocd_class_type;

  // addressing modes
  typedef enum logic [2:0] {
    OCD_AM_NONE = 3'h0,
    OCD_AM_IMM  = 3'h1,
    OCD_AM_DIR  = 3'h2,
    OCD_AM_EXT  = 3'h3,
    OCD_AM_IX   = 3'h4,
    OCD_AM_IX1  = 3'h5,
    OCD_AM_IX2  = 3'h6,
    OCD_AM_REL  = 3'h7
  } ocd_mode_type;

  // column high nibbles of the register/memory group
  localparam logic [3:0] OCD_COL_IMM = 4'hA;
  localparam logic [3:0] OCD_COL_DIR = 4'hB;
  localparam logic [3:0] OCD_COL_EXT = 4'hC;
  localparam logic [3:0] OCD_COL_IX2 = 4'hD;
  localparam logic [3:0] OCD_COL_IX1 = 4'hE;
  localparam logic [3:0] OCD_COL_IX  = 4'hF;

  // low nibbles of the register/memory group
  localparam logic [3:0] OCD_LO_SUB     = 4'h0;
  localparam logic [3:0] OCD_LO_CMPR_A  = 4'h1;
  localparam logic [3:0] OCD_LO_SUBB    = 4'h2;
  localparam logic [3:0] OCD_LO_CMPR_X  = 4'h3;
  localparam logic [3:0] OCD_LO_AND     = 4'h4;
  localparam logic [3:0] OCD_LO_BITTEST = 4'h5;
  localparam logic [3:0] OCD_LO_LOAD_A  = 4'h6;
  localparam logic [3:0] OCD_LO_STORE_A = 4'h7;
  localparam logic [3:0] OCD_LO_XOR     = 4'h8;
  localparam logic [3:0] OCD_LO_ADC     = 4'h9;
  localparam logic [3:0] OCD_LO_ORA     = 4'hA;
  localparam logic [3:0] OCD_LO_ADD     = 4'hB;
  localparam logic [3:0] OCD_LO_JUMP    = 4'hC;
  localparam logic [3:0] OCD_LO_CALL    = 4'hD;
  localparam logic [3:0] OCD_LO_LOAD_X  = 4'hE;
  localparam logic [3:0] OCD_LO_STORE_X = 4'hF;

  // special opcodes
  localparam logic [7:0] OCD_OP_BR_SUB   = 8'hAD;
  localparam logic [3:0] OCD_HI_BITBR    = 4'h0;
  localparam logic [3:0] OCD_HI_BITSC    = 4'h1;
  localparam logic [3:0] OCD_HI_BRANCH   = 4'h2;

  // branch condition codes (low nibble of 2x)
  localparam logic [3:0] OCD_BR_ALWAYS   = 4'h0;
  localparam logic [3:0] OCD_BR_NEVER    = 4'h1;
  localparam logic [3:0] OCD_BR_HI       = 4'h2;
  localparam logic [3:0] OCD_BR_LS       = 4'h3;
  localparam logic [3:0] OCD_BR_CC       = 4'h4;
  localparam logic [3:0] OCD_BR_CS       = 4'h5;
  localparam logic [3:0] OCD_BR_NE       = 4'h6;
  localparam logic [3:0] OCD_BR_EQ       = 4'h7;
  localparam logic [3:0] OCD_BR_HCC      = 4'h8;
  localparam logic [3:0] OCD_BR_HCS      = 4'h9;
  localparam logic [3:0] OCD_BR_PL       = 4'hA;
  localparam logic [3:0] OCD_BR_MI       = 4'hB;
  localparam logic [3:0] OCD_BR_MC       = 4'hC;
  localparam logic [3:0] OCD_BR_MS       = 4'hD;
  localparam logic [3:0] OCD_BR_IL       = 4'hE;
  localparam logic [3:0] OCD_BR_IH       = 4'hF;

  // lengths and cycle counts
  localparam logic [1:0] OCD_LEN_1       = 2'h1;
  localparam logic [1:0] OCD_LEN_2       = 2'h2;
  localparam logic [1:0] OCD_LEN_3       = 2'h3;
  localparam logic [3:0] OCD_CYC_BRANCH  = 4'h3;
  localparam logic [3:0] OCD_CYC_BR_SUB  = 4'h6;
  localparam logic [3:0] OCD_CYC_BIT     = 4'h5;
  localparam logic [3:0] OCD_CYC_GO_DIR  = 4'h2;
  localparam logic [3:0] OCD_CYC_SUB_DIR = 4'h5;
  localparam logic [3:0] OCD_CYC_RM_IMM  = 4'h2;

  // condition flags seen by the branch test
  typedef struct packed {
    logic half_carry;
    logic irq_mask;
    logic negative;
    logic zero;
    logic carry;
  } ocd_flags_type;

  // decoded result
  typedef struct packed {
    logic          valid;
    ocd_class_type cls;
    ocd_mode_type  mode;
    logic [3:0]    alu_op;
    logic          writes_acc;
    logic [2:0]    bit_num;
    logic          bit_sense;
    logic [1:0]    length;
    logic [3:0]    cycles;
    logic          taken;
  } ocd_decode_type;

endpackage : ocd_pkg

// ---- ocd_decoder.sv ----
// Operation
// RL1: subtract with borrow A2 B2 C2 F2 E2 D2
// RL2: add with carry A9..D9, same timing
// RL3: exclusive or A8..D8, E8 four cycles
// RL4: compare acc by subtraction, acc unchanged
// RL5: compare index A3..D3, D3 three bytes five
// RL6: bit test A5..D5 flags only
// RL7: 22 higher, 23 lower-or-same, three cycles
// RL8: 24 carry clear, 25 carry set, aliases
// RL9: 28/29 half-carry clear/set, two bytes
// RL10: 2C/2D mask clear/set, three cycles
// RL11: 2E/2F irq pin low/high sampled directly
// RL12: bit-one branch 2n, three bytes five
// RL13: bit-zero branch 01+2n, same timing
// RL14: set 10+2n, clear 11+2n, five cycles
// RL15: other branches three cycles, subroutine AD six
// RL16: column pattern; stores plus one, no immediate
//
// Purpose: decode one opcode byte into class, mode, length, cycles, branch result
// Assumes: opcode_i, flags_i and irq_pin_i are synchronous to clk_sys_i
// Notes:   result appears one cycle after opcode_valid_i and is held until next
`timescale 1ns/1ps
module ocd_decoder (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   opcode_valid_i,
  input  wire logic [7:0]             opcode_i,
  input  wire ocd_pkg::ocd_flags_type flags_i,
  input  wire logic                   irq_pin_i,
  output      ocd_pkg::ocd_decode_type decode_o
);
  import ocd_pkg::*;

  typedef struct packed {
    ocd_decode_type dec;
  } ocd_state_type;

  ocd_state_type state_reg;
  ocd_state_type state_next;

  // base cycles of a read-type register/memory op per column
  function automatic logic [3:0] rm_cycles(input logic [3:0] col);
    unique case (col)
      OCD_COL_IMM: rm_cycles = OCD_CYC_RM_IMM;
      OCD_COL_DIR: rm_cycles = OCD_CYC_RM_IMM + 4'h1;
      OCD_COL_EXT: rm_cycles = OCD_CYC_RM_IMM + 4'h2;
      OCD_COL_IX2: rm_cycles = OCD_CYC_RM_IMM + 4'h3;
      OCD_COL_IX1: rm_cycles = OCD_CYC_RM_IMM + 4'h2;
      default:     rm_cycles = OCD_CYC_RM_IMM + 4'h1;
    endcase
  endfunction

  // byte length per column
  function automatic logic [1:0] rm_length(input logic [3:0] col);
    if (col == OCD_COL_EXT || col == OCD_COL_IX2)
      rm_length = OCD_LEN_3;
    else if (col == OCD_COL_IX)
      rm_length = OCD_LEN_1;
    else
      rm_length = OCD_LEN_2;
  endfunction

  // branch condition evaluation; irq pin read live, not latched
  function automatic logic branch_test(input logic [3:0] cond, input ocd_flags_type f, input logic pin);
    unique case (cond)
      OCD_BR_ALWAYS: branch_test = 1'b1;                          // RL15
      OCD_BR_NEVER:  branch_test = 1'b0;                          // RL15
      OCD_BR_HI:     branch_test = !(f.carry | f.zero);           // RL7
      OCD_BR_LS:     branch_test = f.carry | f.zero;              // RL7
      OCD_BR_CC:     branch_test = !f.carry;                      // RL8
      OCD_BR_CS:     branch_test = f.carry;                       // RL8
      OCD_BR_NE:     branch_test = !f.zero;                       // RL15
      OCD_BR_EQ:     branch_test = f.zero;                        // RL15
      OCD_BR_HCC:    branch_test = !f.half_carry;                 // RL9
      OCD_BR_HCS:    branch_test = f.half_carry;                  // RL9
      OCD_BR_PL:     branch_test = !f.negative;                   // RL15
      OCD_BR_MI:     branch_test = f.negative;                    // RL15
      OCD_BR_MC:     branch_test = !f.irq_mask;                   // RL10
      OCD_BR_MS:     branch_test = f.irq_mask;                    // RL10
      OCD_BR_IL:     branch_test = !pin;                          // RL11
      default:       branch_test = pin;                           // RL11
    endcase
  endfunction

  logic [3:0] hi_nib;
  logic [3:0] lo_nib;
  assign hi_nib = opcode_i[7:4];
  assign lo_nib = opcode_i[3:0];

  // decode the opcode; undefined codes give valid low
  always_comb begin
    ocd_decode_type d;
    d = '0;
    d.cls  = OCD_CLS_NONE;
    d.mode = OCD_AM_NONE;
    state_next = state_reg;
    if (opcode_valid_i) begin
      if (hi_nib >= OCD_COL_IMM) begin
        // register/memory columns: high nibble picks the mode
        d.valid  = 1'b1;                                          // RL16
        d.length = rm_length(hi_nib);
        d.cycles = rm_cycles(hi_nib);
        d.alu_op = lo_nib;
        unique case (hi_nib)
          OCD_COL_IMM: d.mode = OCD_AM_IMM;
          OCD_COL_DIR: d.mode = OCD_AM_DIR;
          OCD_COL_EXT: d.mode = OCD_AM_EXT;
          OCD_COL_IX2: d.mode = OCD_AM_IX2;
          OCD_COL_IX1: d.mode = OCD_AM_IX1;
          default:     d.mode = OCD_AM_IX;
        endcase
        unique case (lo_nib)
          OCD_LO_CMPR_A, OCD_LO_CMPR_X, OCD_LO_BITTEST: begin
            d.cls = OCD_CLS_COMPARE;                              // RL4 RL5 RL6
          end
          OCD_LO_LOAD_A: begin
            d.cls = OCD_CLS_LOAD_ACC;
            d.writes_acc = 1'b1;
          end
          OCD_LO_LOAD_X: d.cls = OCD_CLS_LOAD_INDEX;
          OCD_LO_STORE_A, OCD_LO_STORE_X: begin
            d.cls    = (lo_nib == OCD_LO_STORE_A) ? OCD_CLS_STORE_ACC : OCD_CLS_STORE_IDX;
            d.cycles = rm_cycles(hi_nib) + 4'h1;                  // RL16
            d.valid  = (hi_nib != OCD_COL_IMM);                   // RL16
          end
          OCD_LO_JUMP: begin
            d.cls    = OCD_CLS_JUMP;
            d.cycles = rm_cycles(hi_nib) - 4'h1;                  // RL16
            d.valid  = (hi_nib != OCD_COL_IMM);                   // RL16
          end
          OCD_LO_CALL: begin
            if (hi_nib == OCD_COL_IMM) begin
              d.cls    = OCD_CLS_BRANCH_SUB;                      // RL15
              d.mode   = OCD_AM_REL;
              d.length = OCD_LEN_2;
              d.cycles = OCD_CYC_BR_SUB;
              d.taken  = 1'b1;
            end else begin
              d.cls    = OCD_CLS_JUMP_SUB;
              d.cycles = rm_cycles(hi_nib) + 4'h2;                // RL16
            end
          end
          default: begin
            // remaining arithmetic and logic ops all write the accumulator
            d.cls = OCD_CLS_ALU;                                  // RL1 RL2 RL3
            d.writes_acc = 1'b1;
          end
        endcase
      end else if (hi_nib == OCD_HI_BRANCH) begin
        d.valid  = 1'b1;
        d.cls    = OCD_CLS_BRANCH;
        d.mode   = OCD_AM_REL;
        d.length = OCD_LEN_2;                                     // RL9
        d.cycles = OCD_CYC_BRANCH;                                // RL7 RL10
        d.taken  = branch_test(lo_nib, flags_i, irq_pin_i);
      end else if (hi_nib == OCD_HI_BITBR) begin
        d.valid     = 1'b1;
        d.cls       = OCD_CLS_BIT_BRANCH;
        d.mode      = OCD_AM_DIR;
        d.bit_num   = opcode_i[3:1];                              // RL12 RL13
        d.bit_sense = !opcode_i[0];                               // RL13
        d.length    = OCD_LEN_3;                                  // RL12
        d.cycles    = OCD_CYC_BIT;
      end else if (hi_nib == OCD_HI_BITSC) begin
        d.valid     = 1'b1;
        d.cls       = OCD_CLS_BIT_SETCLR;
        d.mode      = OCD_AM_DIR;
        d.bit_num   = opcode_i[3:1];                              // RL14
        d.bit_sense = !opcode_i[0];
        d.length    = OCD_LEN_2;
        d.cycles    = OCD_CYC_BIT;                                // RL14
      end
      state_next.dec = d;
    end
  end

  // single register stage; outputs come straight from it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign decode_o = state_reg.dec;

  AST_BRANCH_TIMING: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL7
    opcode_valid_i && opcode_i[7:4] == 4'h2 |=> decode_o.cycles == 4'h3 && decode_o.length == 2'h2)
    else $error("branch timing wrong");
  AST_HI_TEST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL7
    opcode_valid_i && opcode_i == 8'h22 |=> decode_o.taken == !$past(flags_i.carry | flags_i.zero))
    else $error("higher branch test wrong");
  AST_CARRY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL8
    opcode_valid_i && opcode_i == 8'h25 |=> decode_o.taken == $past(flags_i.carry))
    else $error("carry set branch wrong");
  AST_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL11
    opcode_valid_i && opcode_i == 8'h2F |=> decode_o.taken == $past(irq_pin_i))
    else $error("pin high branch wrong");
  AST_SUB_BORROW_IX2: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL1
    opcode_valid_i && opcode_i == 8'hD2 |=> decode_o.length == 2'h3 && decode_o.cycles == 4'h5)
    else $error("subtract with borrow ix2 timing wrong");
  AST_XOR_IX1: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL3
    opcode_valid_i && opcode_i == 8'hE8 |=> decode_o.cycles == 4'h4 && decode_o.writes_acc)
    else $error("exclusive or ix1 wrong");
  AST_CMP_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL4
    opcode_valid_i && opcode_i[3:0] inside {4'h1, 4'h3, 4'h5} && opcode_i[7:4] >= 4'hA
    |=> !decode_o.writes_acc && decode_o.cls == OCD_CLS_COMPARE)
    else $error("compare writes accumulator");
  AST_BITBR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL13
    opcode_valid_i && opcode_i[7:4] == 4'h0
    |=> decode_o.length == 2'h3 && decode_o.cycles == 4'h5 && decode_o.bit_num == $past(opcode_i[3:1]))
    else $error("bit branch decode wrong");
  AST_STORE_NOIMM: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL16
    opcode_valid_i && (opcode_i == 8'hA7 || opcode_i == 8'hAF || opcode_i == 8'hAC) |=> !decode_o.valid)
    else $error("immediate store accepted");
  AST_BITSC: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL14
    opcode_valid_i && opcode_i[7:4] == 4'h1
    |=> decode_o.length == 2'h2 && decode_o.cycles == 4'h5 && decode_o.bit_sense == !$past(opcode_i[0]))
    else $error("bit set or clear decode wrong");
  AST_BRANCH_SUB: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RL15
    opcode_valid_i && opcode_i == 8'hAD |=> decode_o.cycles == 4'h6 && decode_o.cls == OCD_CLS_BRANCH_SUB)
    else $error("subroutine branch wrong");

endmodule // ocd_decoder

// ---- ocd_mem_model.sv ----
// Purpose: program memory seen by the opcode fetch, each byte equal to its address
// Assumes: fetch_i high while the core reads, addr_i steady from one falling edge on
// Notes:   released bus shows the inverse of the last byte, never a stale copy
`timescale 1ns/1ps
module ocd_mem_model (
  input  wire logic       clk_sys_i,
  input  wire logic       fetch_i,
  input  wire logic [7:0] addr_i,
  output      logic [7:0] data_o
);
  logic [7:0] last_reg;

  // identity rom keeps every opcode reachable by address alone
  always_comb data_o = fetch_i ? addr_i : ~last_reg;

  // remember the last byte handed out, so an idle bus cannot pass for it
  always_ff @(posedge clk_sys_i) begin
    if (fetch_i) begin
      last_reg <= addr_i;
    end
  end
endmodule // ocd_mem_model

// ---- ocd_decoder_test.sv ----
// Purpose: self-checking bench for the opcode decode and timing block
// Assumes: fields not fixed by the instruction set are masked out of the compare
// Notes:   expectations queue on drive, a monitor pops one per decode
`timescale 1ns/1ps
module ocd_decoder_test;
  import ocd_pkg::*;
  logic           clk_sys_i;
  logic           rst_n_i;
  logic           opcode_valid_i;
  logic           irq_pin_i;
  logic [7:0]     opcode_i;
  logic [7:0]     fetch_addr;
  ocd_flags_type  flags_i;
  ocd_decode_type decode_o;
  ocd_decode_type exp_q[$];
  ocd_decode_type mask_q[$];
  int             bad_count;
  int             n_tests;

  ocd_mem_model mem (.clk_sys_i(clk_sys_i), .fetch_i(opcode_valid_i), .addr_i(fetch_addr), .data_o(opcode_i));
  ocd_decoder DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .opcode_valid_i(opcode_valid_i),
                   .opcode_i(opcode_i), .flags_i(flags_i), .irq_pin_i(irq_pin_i), .decode_o(decode_o));

  task automatic test_done;
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input ocd_decode_type seen, input ocd_decode_type exp, input ocd_decode_type m);
    n_tests++;
    if ((seen & m) !== (exp & m)) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // fill one decoded class and mark its fields as checked
  function automatic void fill(inout ocd_decode_type e, inout ocd_decode_type m, input ocd_class_type c,
                               input ocd_mode_type md, input logic [1:0] l, input logic [3:0] cy);
    e.valid = 1'b1;
    e.cls = c;
    e.mode = md;
    e.length = l;
    e.cycles = cy;
    m.cls = ocd_class_type'(4'hF);
    m.mode = ocd_mode_type'(3'h7);
    m.length = 2'h3;
    m.cycles = 4'hF;
  endfunction

  // reference decode; unknown memory bit leaves bit-branch taken unchecked
  function automatic void expect_of(input logic [7:0] op, input ocd_flags_type f, input logic irq,
                                    output ocd_decode_type e, output ocd_decode_type m);
    logic [3:0]   lo;
    logic [3:0]   rd;
    logic [15:0]  cond;
    ocd_mode_type md;
    logic [1:0]   len;
    lo = op[3:0];
    e = '0;
    m = '0;
    m.valid = 1'b1;
    cond = {irq, ~irq, f.irq_mask, ~f.irq_mask, f.negative, ~f.negative, f.half_carry, ~f.half_carry,
            f.zero, ~f.zero, f.carry, ~f.carry, f.carry | f.zero, ~(f.carry | f.zero), 1'b0, 1'b1};
    if (op == OCD_OP_BR_SUB) begin
      fill(e, m, OCD_CLS_BRANCH_SUB, OCD_AM_REL, OCD_LEN_2, 4'h6);
      e.taken = 1'b1;
      m.taken = 1'b1;
    end else if (op[7:4] == 4'h2) begin
      fill(e, m, OCD_CLS_BRANCH, OCD_AM_REL, OCD_LEN_2, 4'h3);
      e.taken = cond[lo];
      m.taken = 1'b1;
    end else if (op[7:5] == 3'h0) begin
      if (op[4]) fill(e, m, OCD_CLS_BIT_SETCLR, OCD_AM_NONE, OCD_LEN_2, 4'h5);
      else fill(e, m, OCD_CLS_BIT_BRANCH, OCD_AM_NONE, OCD_LEN_3, 4'h5);
      m.mode = ocd_mode_type'(3'h0);
      e.bit_num = op[3:1];
      e.bit_sense = ~op[0];
      m.bit_num = 3'h7;
      m.bit_sense = 1'b1;
    end else if (op[7:4] >= 4'hA && op != 8'hA7 && op != 8'hAF && op != 8'hAC) begin
      case (op[7:4])
        4'hA:    begin md = OCD_AM_IMM; len = 2'h2; rd = 4'h2; end
        4'hB:    begin md = OCD_AM_DIR; len = 2'h2; rd = 4'h3; end
        4'hC:    begin md = OCD_AM_EXT; len = 2'h3; rd = 4'h4; end
        4'hD:    begin md = OCD_AM_IX2; len = 2'h3; rd = 4'h5; end
        4'hE:    begin md = OCD_AM_IX1; len = 2'h2; rd = 4'h4; end
        default: begin md = OCD_AM_IX;  len = 2'h1; rd = 4'h3; end
      endcase
      case (lo)
        4'h7, 4'hF: rd = rd + 4'h1;
        4'hC:       rd = rd - 4'h1;
        4'hD:       rd = rd + 4'h2;
        default:    rd = rd;
      endcase
      case (lo)
        4'h6:    fill(e, m, OCD_CLS_LOAD_ACC, md, len, rd);
        4'hE:    fill(e, m, OCD_CLS_LOAD_INDEX, md, len, rd);
        4'h7:    fill(e, m, OCD_CLS_STORE_ACC, md, len, rd);
        4'hF:    fill(e, m, OCD_CLS_STORE_IDX, md, len, rd);
        4'hC:    fill(e, m, OCD_CLS_JUMP, md, len, rd);
        4'hD:    fill(e, m, OCD_CLS_JUMP_SUB, md, len, rd);
        default: fill(e, m, OCD_CLS_ALU, md, len, rd);
      endcase
      // compare and bit test only set flags, so they form their own class
      if (lo == 4'h1 || lo == 4'h3 || lo == 4'h5) e.cls = OCD_CLS_COMPARE;
      e.writes_acc = lo inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
      m.writes_acc = 1'b1;
    end
  endfunction

  task automatic issue(input logic [7:0] op, input ocd_flags_type f, input logic irq);
    ocd_decode_type e;
    ocd_decode_type m;
    @(negedge clk_sys_i);
    opcode_valid_i = 1'b1;
    fetch_addr = op;
    flags_i = f;
    irq_pin_i = irq;
    expect_of(op, f, irq, e, m);
    exp_q.push_back(e);
    mask_q.push_back(m);
  endtask

  // idle cycles scramble the address so a missed fetch cannot look right
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      opcode_valid_i = 1'b0;
      fetch_addr = 8'($urandom);
    end
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // result lands one cycle after each accepted opcode
  always @(posedge clk_sys_i) begin
    if (rst_n_i === 1'b1 && opcode_valid_i === 1'b1) begin
      #1;
      chk(decode_o, exp_q.pop_front(), mask_q.pop_front());
    end
  end

  // about 1900 cycles of traffic; far past that means a hang
  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  initial begin
    void'($urandom(25826));
    rst_n_i = 1'b0;
    opcode_valid_i = 1'b0;
    fetch_addr = 8'h00;
    flags_i = '0;
    irq_pin_i = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    // every opcode back to back, refused ones included
    for (int i = 0; i < 256; i++) issue(8'(i), ocd_flags_type'(5'($urandom)), 1'($urandom));
    // every branch against every flag and pin combination
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 64; j++) issue(8'h20 + 8'(i), ocd_flags_type'(j[4:0]), j[5]);
    end
    idle(2);
    // reset in mid-run clears the result
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    chk(decode_o, '0, '1);
    rst_n_i = 1'b1;
    repeat (300) begin
      issue(8'($urandom), ocd_flags_type'(5'($urandom)), 1'($urandom));
      idle($urandom_range(0, 2));
    end
    idle(3);
    test_done();
  end
endmodule // ocd_decoder_test
